//--- design/acd_defs.svh
// acd_defs.svh: offsets, field positions, reset values and constants of the correction/dma block
// assumes: included by bare name; definitions only
`ifndef ACD_DEFS_SVH
`define ACD_DEFS_SVH

// ****************************************************************
// register byte offsets
// ****************************************************************
`define ACD_OFS_CFG     8'h00
`define ACD_OFS_OFFSET  8'h04
`define ACD_OFS_GAIN    8'h08
`define ACD_OFS_DMABEG  8'h0C
`define ACD_OFS_DMASIZE 8'h10
`define ACD_OFS_DMACFG  8'h14
`define ACD_OFS_DMACUR  8'h18
`define ACD_OFS_FLAG    8'h1C
`define ACD_OFS_MASK    8'h20
`define ACD_OFS_DATA    8'h24

// ****************************************************************
// field positions
// ****************************************************************
`define ACD_CFG_ENABLE  0
`define ACD_CFG_PER_LO  1
`define ACD_CFG_PER_HI  3
`define ACD_CFG_MUXN_LO 4
`define ACD_CFG_MUXN_HI 7
`define ACD_CFG_MUXP_LO 8
`define ACD_CFG_MUXP_HI 11
`define ACD_CFG_REFOUT  12
`define ACD_DMA_LOAD    0
`define ACD_DMA_WRAP    1
`define ACD_DMA_RST     4
`define ACD_FLG_HALF    0
`define ACD_FLG_FULL    1
`define ACD_FLG_OVF     2
`define ACD_FLG_SAT     3
`define ACD_FLG_DATA    4

// ****************************************************************
// reset values and numeric limits
// ****************************************************************
`define ACD_RST_OFFSET  16'h0000
`define ACD_RST_GAIN    16'h8000
`define ACD_POS_LIMIT   16'h7FFF
`define ACD_NEG_LIMIT   16'h8000
`define ACD_MIN_CLOCKS  12'h020
`define ACD_FLAG_W      5

`endif

//--- design/acd_pkg.sv
// acd_pkg.sv: types shared by the correction/dma block
// assumes: nothing beyond a SystemVerilog compiler
package acd_pkg;
  // dma channel states, gray along idle -> run -> stop
  typedef enum logic [1:0] {
    ACD_IDLE = 2'b00,
    ACD_RUN  = 2'b01,
    ACD_STOP = 2'b11
  } acd_dma_state_t;
endpackage

//--- design/acd_corr_if.sv
// acd_corr_if.sv: carries the raw sample into the correction stage and the result back
// assumes: both ends on the same clock
interface acd_corr_if;
  logic        in_valid;
  logic [15:0] raw;
  logic [15:0] offset;
  logic [15:0] gain;
  logic        out_valid;
  logic [15:0] sample;
  logic        saturated;
  modport ctl  (output in_valid, output raw, output offset, output gain,
                input out_valid, input sample, input saturated);
  modport corr (input in_valid, input raw, input offset, input gain,
                output out_valid, output sample, output saturated);
endinterface

//--- design/acd_corr.sv
// acd_corr.sv: offset add, fixed-point gain with clamp, halving; one cycle of latency
// assumes: clk_i/rst_i shared with the controller
`include "acd_defs.svh"
module acd_corr (
  // clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  // correction channel
  acd_corr_if.corr  c
);
  logic signed [16:0] sum;
  logic signed [33:0] prod;
  logic signed [18:0] scaled;
  logic        [15:0] clamp;
  logic               sat;
  logic               valid_reg, valid_next;
  logic        [15:0] sample_reg, sample_next;
  logic               sat_reg, sat_next;

  // ****************************************************************
  // arithmetic
  // ****************************************************************
  always_comb begin
    sum    = 17'(signed'(c.raw)) + 17'(signed'(c.offset));        // see [R3]
    prod   = 34'(sum) * signed'({18'h00000, c.gain});             // see [R6]
    scaled = 19'(prod >>> 15);
    sat    = 1'b0;
    clamp  = scaled[15:0];
    if (scaled > 19'sh07FFF) begin                                // see [R4]
      clamp = `ACD_POS_LIMIT;
      sat   = 1'b1;
    end else if (scaled < -19'sh08000) begin
      clamp = `ACD_NEG_LIMIT;
      sat   = 1'b1;
    end
    valid_next  = c.in_valid;
    sample_next = c.in_valid ? {clamp[15], clamp[15:1]} : sample_reg;  // see [R5] see [R26]
    sat_next    = c.in_valid & sat;
  end

  // result registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      valid_reg  <= 1'b0;
      sample_reg <= 16'h0000;
      sat_reg    <= 1'b0;
    end else begin
      valid_reg  <= valid_next;
      sample_reg <= sample_next;
      sat_reg    <= sat_next;
    end
  end

  assign c.out_valid = valid_reg;
  assign c.sample    = sample_reg;
  assign c.saturated = sat_reg;
endmodule

//--- design/acd_top.sv
// acd_top.sv: converter digital back end with correction, dma writer and wishbone registers
// assumes: modulator delivers done_i pulses with raw data on clk_i; ram write port acks
// Functional notes
// [R1] software sets converter pins to analog mode
// [R2] reference drive needs enable and analog pin
// [R3] add signed offset to raw result
// [R4] gain multiply, clamp to 16-bit, flag saturation
// [R5] halve corrected value for final sample
// [R6] gain is unsigned 1.15 fixed point
// [R7] reset offset zero, gain 0x8000
// [R8] dma writes each corrected sample to buffer
// [R9] software keeps buffer start address even
// [R10] buffer size counts 16-bit samples
// [R11] software resets channel then sets load
// [R12] wrap bit picks linear or auto-wrap
// [R13] linear stops at count, sets full
// [R14] linear: conversion after full sets overflow
// [R15] wrap mode returns pointer to start
// [R16] half and full flags per buffer half
// [R17] current write address readable
// [R18] input selects route analog inputs
// [R19] always differential; half reference for single-ended
// [R20] software writes converter configuration last
// [R21] flag cleared by writing one
// [R22] mask gates flags onto interrupt request
// [R23] result with dma disabled sets overflow
// [R24] period field 32 to 4096 clocks
// [R25] pointer steps two bytes; reset returns start
// [R26] clamped value goes into halving
`include "acd_defs.svh"
module acd_top #(
  parameter int AW = 32
) (
  // clock and reset
  input  wire logic          clk_i,
  input  wire logic          rst_i,
  // wishbone slave
  input  wire logic          wb_cyc_i,
  input  wire logic          wb_stb_i,
  input  wire logic          wb_we_i,
  input  wire logic [7:0]    wb_adr_i,
  input  wire logic [3:0]    wb_sel_i,
  input  wire logic [31:0]   wb_dat_i,
  output logic      [31:0]   wb_dat_o,
  output logic               wb_ack_o,
  // converter core
  input  wire logic          conv_done_i,
  input  wire logic [15:0]   conv_raw_i,
  input  wire logic          ref_pin_analog_i,
  output logic               conv_enable_o,
  output logic      [2:0]    sample_period_o,
  output logic      [3:0]    positive_input_select_o,
  output logic      [3:0]    negative_input_select_o,
  output logic               reference_pin_drive_o,
  output logic               irq_o,
  // ram write port
  output logic               ram_req_o,
  output logic      [AW-1:0] ram_addr_o,
  output logic      [15:0]   ram_data_o,
  input  wire logic          ram_ack_i
);
  acd_corr_if cif ();

  // ****************************************************************
  // state
  // ****************************************************************
  // register file
  logic [15:0] cfg_reg, cfg_next;
  logic [15:0] offset_reg, offset_next;
  logic [15:0] gain_reg, gain_next;
  logic [AW-1:0] beg_reg, beg_next;
  logic [15:0] size_reg, size_next;
  // dma channel
  logic        wrap_reg, wrap_next;
  logic [AW-1:0] cur_reg, cur_next;
  logic [15:0] cnt_reg, cnt_next;
  logic [`ACD_FLAG_W-1:0] flag_reg, flag_next;
  logic [`ACD_FLAG_W-1:0] mask_reg, mask_next;
  logic [15:0] data_reg, data_next;
  acd_pkg::acd_dma_state_t st_reg, st_next;
  logic        req_reg, req_next;
  logic [15:0] wdat_reg, wdat_next;
  // bus answer
  logic        ack_reg, ack_next;
  logic [31:0] rdat_reg, rdat_next;
  // pin and interrupt outputs
  logic        ref_s1_reg, ref_s2_reg;
  logic        drive_reg, drive_next;
  logic        irq_reg, irq_next;

  // scratch values of the next-state process
  logic        wr_hit;
  logic [31:0] wmask;
  logic [31:0] wval;
  logic [15:0] half_pt;
  logic [`ACD_FLAG_W-1:0] set_flags;
  logic [`ACD_FLAG_W-1:0] clr_flags;

  // ****************************************************************
  // correction stage
  // ****************************************************************
  assign cif.in_valid = conv_done_i & cfg_reg[`ACD_CFG_ENABLE];
  assign cif.raw      = conv_raw_i;   // left-aligned 16-bit result, see [R24]
  assign cif.offset   = offset_reg;
  assign cif.gain     = gain_reg;

  acd_corr u_corr (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .c     (cif)
  );

  // reference pin level synchroniser; the pin is asynchronous, so only the
  // second stage feeds logic
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ref_s1_reg <= 1'b0;
      ref_s2_reg <= 1'b0;
    end else begin
      ref_s1_reg <= ref_pin_analog_i;
      ref_s2_reg <= ref_s1_reg;
    end
  end

  // ****************************************************************
  // next-state logic
  // ****************************************************************
  always_comb begin
    // a write lands at the edge that also samples ack high, as the master expects
    wr_hit      = wb_cyc_i & wb_stb_i & wb_we_i & ack_reg;
    wmask       = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    wval        = wb_dat_i & wmask;
    half_pt     = size_reg >> 1;
    cfg_next    = cfg_reg;
    offset_next = offset_reg;
    gain_next   = gain_reg;
    beg_next    = beg_reg;
    size_next   = size_reg;
    wrap_next   = wrap_reg;
    mask_next   = mask_reg;
    cur_next    = cur_reg;
    cnt_next    = cnt_reg;
    st_next     = st_reg;
    req_next    = req_reg;
    wdat_next   = wdat_reg;
    data_next   = cif.out_valid ? cif.sample : data_reg;
    set_flags   = '0;
    clr_flags   = '0;
    if (cif.saturated)
      set_flags[`ACD_FLG_SAT] = 1'b1;                             // see [R4]
    if (cif.out_valid)
      set_flags[`ACD_FLG_DATA] = 1'b1;
    // register writes
    if (wr_hit) begin
      case (wb_adr_i)
        `ACD_OFS_CFG:     cfg_next    = (cfg_reg & ~wmask[15:0]) | wval[15:0];  // see [R18]
        `ACD_OFS_OFFSET:  offset_next = (offset_reg & ~wmask[15:0]) | wval[15:0];
        `ACD_OFS_GAIN:    gain_next   = (gain_reg & ~wmask[15:0]) | wval[15:0];
        `ACD_OFS_DMABEG:  beg_next    = (beg_reg & ~wmask[AW-1:0]) | wval[AW-1:0];
        `ACD_OFS_DMASIZE: size_next   = (size_reg & ~wmask[15:0]) | wval[15:0];  // see [R10]
        `ACD_OFS_MASK:    mask_next   = wval[`ACD_FLAG_W-1:0] |
                                        (mask_reg & ~wmask[`ACD_FLAG_W-1:0]);
        `ACD_OFS_FLAG:    clr_flags   = wval[`ACD_FLAG_W-1:0];   // see [R21]
        // reset wins over load when both bits are written
        `ACD_OFS_DMACFG: begin
          if (wb_sel_i[0]) begin
            wrap_next = wb_dat_i[`ACD_DMA_WRAP];                  // see [R12]
            if (wb_dat_i[`ACD_DMA_RST]) begin
              st_next  = acd_pkg::ACD_IDLE;                       // see [R25]
              cur_next = beg_reg;
              cnt_next = 16'h0000;
              req_next = 1'b0;
            end else if (wb_dat_i[`ACD_DMA_LOAD]) begin
              st_next  = acd_pkg::ACD_RUN;
              cur_next = beg_reg;
              cnt_next = 16'h0000;
            end
          end
        end
        default: ;
      endcase
    end
    // dma: ram write completion advances pointer and count
    if (req_reg & ram_ack_i) begin
      req_next = 1'b0;
      cnt_next = cnt_reg + 16'h0001;
      cur_next = cur_reg + AW'(2);                                // see [R25]
      if (cnt_reg + 16'h0001 == half_pt)
        set_flags[`ACD_FLG_HALF] = 1'b1;                          // see [R16]
      if (cnt_reg + 16'h0001 >= size_reg) begin
        set_flags[`ACD_FLG_FULL] = 1'b1;                          // see [R13] see [R16]
        if (wrap_reg) begin
          cur_next = beg_reg;                                     // see [R15]
          cnt_next = 16'h0000;
        end else begin
          st_next = acd_pkg::ACD_STOP;
        end
      end
    end
    // new sample launches a write or counts as overflow
    if (cif.out_valid) begin
      case (st_reg)
        acd_pkg::ACD_RUN: begin
          if (!req_reg) begin
            req_next  = 1'b1;                                     // see [R8]
            wdat_next = cif.sample;
          end else begin
            set_flags[`ACD_FLG_OVF] = 1'b1;
          end
        end
        acd_pkg::ACD_STOP: set_flags[`ACD_FLG_OVF] = 1'b1;        // see [R14]
        default:           set_flags[`ACD_FLG_OVF] = 1'b1;        // see [R23]
      endcase
    end
    // switching the converter off ends a running transfer; only the falling
    // enable counts, so a channel loaded before the converter starts stays armed,
    // and a write already in flight still completes
    if (cfg_reg[`ACD_CFG_ENABLE] && !cfg_next[`ACD_CFG_ENABLE] &&
        st_reg == acd_pkg::ACD_RUN)
      st_next = acd_pkg::ACD_IDLE;                                // see [R15]
    // a hardware set beats a software clear in the same cycle
    flag_next  = (flag_reg & ~clr_flags) | set_flags;             // see [R21]
    irq_next   = |(flag_next & mask_next);                        // see [R22]
    drive_next = cfg_reg[`ACD_CFG_REFOUT] & cfg_reg[`ACD_CFG_ENABLE] & ref_s2_reg;  // see [R2]
    // bus answer, one wait state: read data is captured at the taking edge
    // and shown only while ack stands
    ack_next  = wb_cyc_i & wb_stb_i & ~ack_reg;
    rdat_next = 32'h0000_0000;
    if (wb_cyc_i & wb_stb_i & ~wb_we_i & ~ack_reg) begin
      case (wb_adr_i)
        `ACD_OFS_CFG:     rdat_next = {16'h0000, cfg_reg};
        `ACD_OFS_OFFSET:  rdat_next = {16'h0000, offset_reg};
        `ACD_OFS_GAIN:    rdat_next = {16'h0000, gain_reg};
        `ACD_OFS_DMABEG:  rdat_next = 32'(beg_reg);
        `ACD_OFS_DMASIZE: rdat_next = {16'h0000, size_reg};
        `ACD_OFS_DMACFG:  rdat_next = 32'({wrap_reg, st_reg == acd_pkg::ACD_RUN});
        `ACD_OFS_DMACUR:  rdat_next = 32'(cur_reg);               // see [R17]
        `ACD_OFS_FLAG:    rdat_next = 32'(flag_reg);
        `ACD_OFS_MASK:    rdat_next = 32'(mask_reg);
        `ACD_OFS_DATA:    rdat_next = {16'h0000, data_reg};
        default:          rdat_next = 32'h0000_0000;
      endcase
    end
  end

  // ****************************************************************
  // registers
  // ****************************************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cfg_reg    <= 16'h0000;
      offset_reg <= `ACD_RST_OFFSET;                              // see [R7]
      gain_reg   <= `ACD_RST_GAIN;                                // see [R7]
      beg_reg    <= '0;
      size_reg   <= 16'h0000;
      wrap_reg   <= 1'b0;
      cur_reg    <= '0;
      cnt_reg    <= 16'h0000;
      flag_reg   <= '0;
      mask_reg   <= '0;
      data_reg   <= 16'h0000;
      st_reg     <= acd_pkg::ACD_IDLE;
      req_reg    <= 1'b0;
      wdat_reg   <= 16'h0000;
      ack_reg    <= 1'b0;
      rdat_reg   <= 32'h0000_0000;
      drive_reg  <= 1'b0;
      irq_reg    <= 1'b0;
    end else begin
      cfg_reg    <= cfg_next;
      offset_reg <= offset_next;
      gain_reg   <= gain_next;
      beg_reg    <= beg_next;
      size_reg   <= size_next;
      wrap_reg   <= wrap_next;
      cur_reg    <= cur_next;
      cnt_reg    <= cnt_next;
      flag_reg   <= flag_next;
      mask_reg   <= mask_next;
      data_reg   <= data_next;
      st_reg     <= st_next;
      req_reg    <= req_next;
      wdat_reg   <= wdat_next;
      ack_reg    <= ack_next;
      rdat_reg   <= rdat_next;
      drive_reg  <= drive_next;
      irq_reg    <= irq_next;
    end
  end

  // outputs straight from flip-flops; inputs always differential, see [R19]
  assign wb_dat_o                = rdat_reg;
  assign wb_ack_o                = ack_reg;
  assign conv_enable_o           = cfg_reg[`ACD_CFG_ENABLE];
  assign sample_period_o         = cfg_reg[`ACD_CFG_PER_HI:`ACD_CFG_PER_LO];  // see [R24]
  assign positive_input_select_o = cfg_reg[`ACD_CFG_MUXP_HI:`ACD_CFG_MUXP_LO];  // see [R18]
  assign negative_input_select_o = cfg_reg[`ACD_CFG_MUXN_HI:`ACD_CFG_MUXN_LO];
  assign reference_pin_drive_o   = drive_reg;
  assign irq_o                   = irq_reg;
  assign ram_req_o               = req_reg;
  assign ram_addr_o              = cur_reg;
  assign ram_data_o              = wdat_reg;
endmodule

//--- testbench/acd_assertions.sv
// acd_assertions.sv: port-level checks for the correction/dma block
// assumes: bound to acd_top; one clock with a synchronous active-high reset
module acd_chk #(
  parameter int AW = 32
) (
  // clock and reset
  input  wire logic          clk_i,
  input  wire logic          rst_i,
  // register bus
  input  wire logic          wb_cyc_i,
  input  wire logic          wb_stb_i,
  input  wire logic          wb_ack_o,
  input  wire logic [31:0]   wb_dat_o,
  // converter side
  input  wire logic          conv_done_i,
  input  wire logic          conv_enable_o,
  input  wire logic          reference_pin_drive_o,
  input  wire logic          irq_o,
  // ram side
  input  wire logic          ram_req_o,
  input  wire logic [AW-1:0] ram_addr_o,
  input  wire logic [15:0]   ram_data_o,
  input  wire logic          ram_ack_i
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // *****
  // bus answer
  // *****
  a_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("bus request not answered next cycle");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data outside ack cycle");
  // *****
  // converter and dma writes
  // *****
  a_ref_gate: assert property (
    reference_pin_drive_o |-> conv_enable_o || $past(conv_enable_o))
    else $error("reference driven while converter off");
  a_req_cause: assert property ($rose(ram_req_o) |-> $past(conv_done_i, 2))
    else $error("ram write without conversion two cycles before");
  a_req_hold: assert property (
    ram_req_o && !ram_ack_i |=> ram_req_o && $stable(ram_addr_o) && $stable(ram_data_o))
    else $error("ram request changed before ack");
  a_req_drop: assert property (ram_req_o && ram_ack_i |=> !ram_req_o)
    else $error("ram request held after ack");
  a_addr_even: assert property (ram_req_o |-> !ram_addr_o[0])
    else $error("odd ram write address");
  a_reset_quiet: assert property ($fell(rst_i) |-> !conv_enable_o && !ram_req_o && !irq_o && !wb_ack_o)
    else $error("outputs active after reset");
endmodule

bind acd_top acd_chk #(.AW(AW)) u_chk (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o), .conv_done_i(conv_done_i),
  .conv_enable_o(conv_enable_o), .reference_pin_drive_o(reference_pin_drive_o), .irq_o(irq_o),
  .ram_req_o(ram_req_o), .ram_addr_o(ram_addr_o), .ram_data_o(ram_data_o), .ram_ack_i(ram_ack_i));

//--- testbench/acd_ram_model.sv
// acd_ram_model.sv: system ram taking dma sample writes with an adjustable answer delay
// assumes: same clock as acd_top; the bench sets lat_i between writes
module acd_ram #(
  parameter int AW = 32
) (
  // clock and reset
  input  wire logic          clk_i,
  input  wire logic          rst_i,
  // write port
  input  wire logic          req_i,
  input  wire logic [AW-1:0] addr_i,
  input  wire logic [15:0]   data_i,
  input  wire logic [1:0]    lat_i,
  output logic               ack_o
);
  logic [1:0]     cnt;
  logic [AW+15:0] log_q[$];
  // count the delay, answer with a one-cycle ack, keep what was accepted
  always @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      cnt <= 2'h0;
    end else if (ack_o) begin
      ack_o <= 1'b0;
      log_q.push_back({addr_i, data_i});
    end else if (req_i && cnt == lat_i) begin
      ack_o <= 1'b1;
      cnt <= 2'h0;
    end else if (req_i) begin
      cnt <= cnt + 2'h1;
    end
  end
endmodule

//--- testbench/adc_correction_dma_tb_top.sv
// adc_correction_dma_tb_top.sv: self-checking bench for acd_top
// assumes: acd_chk bound in, acd_ram as the far side of the ram port
module adc_correction_dma_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk_i, rst_i, wb_cyc, wb_stb, wb_we, wb_ack, done, ref_an, ram_req, ram_ack;
  logic        en_o, refdrv, irq;
  logic [1:0]  lat;
  logic [2:0]  per;
  logic [3:0]  wb_sel, mp, mn;
  logic [7:0]  wb_adr;
  logic [15:0] raw, raw_v, ofs, gn, ram_data;
  logic [16:0] ex;
  logic [31:0] wb_wd, wb_rd, rd, ram_addr, beg;
  logic [15:0] cr[3] = '{16'h7FFF, 16'h8000, 16'h8000};
  logic [15:0] cg[3] = '{16'hFFFF, 16'hFFFF, 16'h8000};
  int          error_cnt, checks;
  // design and far-side ram
  acd_top dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
    .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_wd), .wb_dat_o(wb_rd),
    .wb_ack_o(wb_ack), .conv_done_i(done), .conv_raw_i(raw), .ref_pin_analog_i(ref_an),
    .conv_enable_o(en_o), .sample_period_o(per), .positive_input_select_o(mp),
    .negative_input_select_o(mn), .reference_pin_drive_o(refdrv), .irq_o(irq),
    .ram_req_o(ram_req), .ram_addr_o(ram_addr), .ram_data_o(ram_data), .ram_ack_i(ram_ack));
  acd_ram ram (.clk_i(clk_i), .rst_i(rst_i), .req_i(ram_req), .addr_i(ram_addr),
    .data_i(ram_data), .lat_i(lat), .ack_o(ram_ack));
  // 20 MHz clock
  always #25 clk_i = ~clk_i;
  // *****
  // helpers
  // *****
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  // one classic wishbone cycle, read data left in rd
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_i);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= w;
    wb_adr <= a;
    wb_wd <= d;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack !== 1'b1 && n < 20);
    rd = wb_rd;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_we <= 1'b0;
    if (n >= 20) begin
      chk("bus ack", 1, 0);
      wrap_up();
    end
  endtask
  // one conversion pulse, then wait for the ram write if one is due
  task automatic samp(input logic [15:0] r, input int w);
    int n;
    n = ram.log_q.size();
    @(posedge clk_i);
    done <= 1'b1;
    raw <= r;
    lat <= 2'($urandom);
    @(posedge clk_i);
    done <= 1'b0;
    raw <= 16'($urandom);
    for (int i = 0; i < 16 && ram.log_q.size() == n; i++) @(posedge clk_i);
    chk("ram writes", n + w, ram.log_q.size());
  endtask
  // offset, 1.15 gain, clamp, halve: {saturated, sample}
  function automatic logic [16:0] corr(input logic [15:0] r, o, g);
    longint s, p;
    s = $signed(r) + $signed(o);
    p = (s * longint'(g)) >>> 15;
    if (p > 32767) return {1'b1, 16'h3FFF};
    if (p < -32768) return {1'b1, 16'hC000};
    return {1'b0, 16'(p >>> 1)};
  endfunction
  // *****
  // main sequence
  // *****
  initial begin
    clk_i = 0; rst_i = 1; wb_cyc = 0; wb_stb = 0; wb_we = 0; wb_adr = 0; wb_sel = 4'hF;
    wb_wd = 0; done = 0; raw = 0; ref_an = 0; lat = 0; error_cnt = 0; checks = 0;
    void'($urandom(32'hED9F6A8F));
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    bus(0, 8'h04, 0); chk("offset reset", 32'h0, rd);
    bus(0, 8'h08, 0); chk("gain reset", 32'h8000, rd);
    bus(1, 8'h3C, 32'hFFFFFFFF); bus(0, 8'h3C, 0); chk("unmapped", 32'h0, rd);
    // dma set up first, converter configuration last
    bus(1, 8'h0C, 32'h100);
    bus(1, 8'h10, 64);
    bus(1, 8'h14, 32'h10);
    bus(1, 8'h14, 32'h03);
    bus(1, 8'h00, 32'h159F); // enable, period 7, neg 9, pos 5, reference out
    @(negedge clk_i);
    chk("enable", 1, en_o);
    chk("pos sel", 5, mp);
    chk("neg sel", 9, mn);
    chk("period", 7, per);
    chk("ref drive off", 0, refdrv);
    @(posedge clk_i);
    ref_an <= 1'b1;
    repeat (6) @(posedge clk_i);
    chk("ref drive on", 1, refdrv);
    bus(0, 8'h14, 0); chk("dma armed", 32'h3, rd & 32'h3);
    $display("test config done");
    for (int i = 0; i < 20; i++) begin
      raw_v = i < 3 ? cr[i] : 16'($urandom);
      ofs = i < 3 ? 16'h0 : raw_v[15] ? {4'h0, 12'($urandom)} : -{4'h0, 12'($urandom)};
      gn = i < 3 ? cg[i] : 16'($urandom);
      bus(1, 8'h04, {16'h0, ofs});
      bus(1, 8'h08, {16'h0, gn});
      ex = corr(raw_v, ofs, gn);
      samp(raw_v, 1);
      chk("ram data", ex[15:0], ram.log_q[$][15:0]);
      chk("ram addr", 32'h100 + 2 * i, ram.log_q[$][47:16]);
      bus(0, 8'h24, 0); chk("data reg", ex[15:0], rd);
      bus(0, 8'h1C, 0); chk("sat flag", ex[16], rd[3]);
      bus(1, 8'h1C, 32'h1F);
    end
    $display("test correction done");
    beg = 32'h200 + 2 * $urandom_range(0, 127);
    bus(1, 8'h0C, beg);
    bus(1, 8'h10, 4);
    bus(1, 8'h14, 32'h10);
    bus(1, 8'h14, 32'h01);
    bus(1, 8'h1C, 32'h1F);
    for (int i = 0; i < 4; i++) begin
      samp(16'($urandom), 1);
      chk("lin addr", beg + 2 * i, ram.log_q[$][47:16]);
      bus(0, 8'h1C, 0);
      chk("half flag", i >= 1, rd[0]);
      chk("full flag", i == 3, rd[1]);
      if (i == 1) begin
        bus(0, 8'h18, 0); chk("cur addr", beg + 4, rd);
      end
    end
    bus(0, 8'h14, 0); chk("running", 0, rd[0]);
    samp(16'h1234, 0);
    bus(0, 8'h1C, 0); chk("overflow", 1, rd[2]);
    bus(1, 8'h1C, 0); bus(0, 8'h1C, 0); chk("zero keeps", 32'h7, rd & 32'h7);
    bus(1, 8'h20, 32'h02); @(negedge clk_i); chk("irq on", 1, irq);
    bus(1, 8'h20, 32'h00); @(negedge clk_i); chk("irq off", 0, irq);
    bus(1, 8'h1C, 32'h02); bus(0, 8'h1C, 0); chk("one clears", 0, rd[1]);
    $display("test linear done");
    bus(1, 8'h10, 3);
    bus(1, 8'h14, 32'h10);
    bus(1, 8'h14, 32'h03);
    bus(0, 8'h14, 0); chk("wrap bit", 32'h3, rd & 32'h3);
    for (int i = 0; i < 4; i++) begin
      samp(16'($urandom), 1);
      chk("wrap addr", beg + 2 * (i % 3), ram.log_q[$][47:16]);
    end
    // converter off ends the wrapping transfer, then it is switched back on
    bus(1, 8'h00, 32'h159E);
    bus(0, 8'h14, 0); chk("off stops", 32'h2, rd & 32'h3);
    bus(1, 8'h00, 32'h159F);
    $display("test wrap done");
    bus(1, 8'h14, 32'h10); bus(0, 8'h18, 0); chk("cur reset", beg, rd);
    bus(1, 8'h1C, 32'h1F);
    samp(16'($urandom), 0);
    bus(0, 8'h1C, 0); chk("idle overflow", 1, rd[2]);
    $display("test dma reset done");
    wrap_up();
  end
endmodule
